// file: mm_map.svh
// constants of the module management control block: timing figures and reset values
// assumes a 20 MHz core clock; included by the package and by the module
`ifndef MM_MAP_SVH
`define MM_MAP_SVH

// ****************************************
// clock and timing figures
// ****************************************
`define MM_MCLK_PERIOD_NS   50
`define MM_RST_MIN_NS       2000
`define MM_INIT_MS          2000
`define MM_RST_MIN_CYC      ((`MM_RST_MIN_NS + `MM_MCLK_PERIOD_NS - 1) / `MM_MCLK_PERIOD_NS)
`define MM_INIT_CYC         ((`MM_INIT_MS * 1000000) / `MM_MCLK_PERIOD_NS)

// ****************************************
// field layout and reset values
// ****************************************
`define MM_NLOS             4
`define MM_NTXF             4
`define MM_NOTH             4
`define MM_NFLAG            (`MM_NLOS + `MM_NTXF + `MM_NOTH)
`define MM_LOS_LSB          0
`define MM_TXF_LSB          4
`define MM_OTH_LSB          8
`define MM_MASK_RST         12'h000
`define MM_PDOWN_RST        1'b0
`define MM_DNR_RST          1'b1

`endif

// file: mm_pkg.sv
// types shared by the module management control block
// assumes mm_map.svh is on the include path
package mm_pkg;
  `include "mm_map.svh"

  // init phases, one-hot
  typedef enum logic [2:0]
  {
    ST_HOLD  = 3'b001,
    ST_INIT  = 3'b010,
    ST_READY = 3'b100
  } phase_t;

  // control word written over the two-wire bus
  typedef struct packed
  {
    logic [`MM_NFLAG-1:0] mask;
    logic                 pdown;
  } ctl_word_t;
endpackage

// file: mm_ctrl.sv
// management control and status logic of a pluggable optical module
// assumes a two-wire bus engine in the link clock domain that reports stop-bit events
//
// Contract
// [R1] reset pin low for at least 2 us resets the module; host holds it that long
// [R2] fully functional and answering the bus within 2000 ms of power-on or reset release
// [R3] within 2000 ms clear data-not-ready and assert the interrupt output
// [R4] low-power pin high enters lower power within 100 us
// [R5] interrupt output goes low within 200 ms of any triggering condition
// [R6] reading flags clears them; interrupt returns high within 500 us of that stop
// [R7] receive loss-of-signal sets its flag and interrupt within 100 ms
// [R8] transmitter fault sets its flag and interrupt within 200 ms
// [R9] any other condition sets its flag and interrupt within 200 ms
// [R10] setting a mask bit inhibits that flag's interrupt within 100 ms
// [R11] clearing a mask bit restores that flag's interrupt within 100 ms
// [R12] select low makes the module answer the bus within 100 us
// [R13] select released stops bus answers within 100 us
// [R14] setting power-down enters lower power within 100 ms
// [R15] clearing power-down returns full function within 300 ms
// [R16] write-started delays count from the clock edge after the write's stop bit
// [R17] while the reset pin is low, logic stays reset and the bus is not answered
`timescale 1ns/1ns
`include "mm_map.svh"
module mm_ctrl
  import mm_pkg::*;
#(
  parameter int INIT_CYCLES = `MM_INIT_CYC
)
(
  // core clock and power-on reset
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst_n,
  // sideband pins from the host
  input  wire logic                 i_reset_in_n,
  input  wire logic                 i_select_in_n,
  input  wire logic                 i_low_power_pin,
  // optical front-end conditions, asynchronous levels
  input  wire logic [`MM_NLOS-1:0]  i_los,
  input  wire logic [`MM_NTXF-1:0]  i_tx_fault,
  input  wire logic [`MM_NOTH-1:0]  i_other_cond,
  // two-wire bus engine, link clock domain
  input  wire logic                 i_link_clk,
  input  wire logic                 i_rd_stop,
  input  wire logic                 i_wr_stop,
  input  wire ctl_word_t            i_wr_word,
  output logic                      o_respond,
  // status and control readback
  output logic                      o_irq_out_n,
  output logic                      o_data_not_ready,
  output logic [`MM_NFLAG-1:0]      o_flags,
  output logic [`MM_NFLAG-1:0]      o_mask,
  output logic                      o_pdown,
  output logic                      o_low_power
);

  localparam int RST_MIN = `MM_RST_MIN_CYC;
  localparam int NF      = `MM_NFLAG;

  // ****************************************
  // link domain
  // ****************************************
  ctl_word_t wr_q, wr_d;
  logic      wtg_q, wtg_d, rtg_q, rtg_d;
  logic      rsp1_q, rsp2_q;
  logic      resp_q, resp_d;

  // write data is held stable while its toggle crosses to the core
  always_comb
  begin
    wr_d  = i_wr_stop ? i_wr_word : wr_q;
    wtg_d = wtg_q ^ i_wr_stop;
    rtg_d = rtg_q ^ i_rd_stop;
  end

  always_ff @(posedge i_link_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_q   <= '{mask: `MM_MASK_RST, pdown: `MM_PDOWN_RST};
      wtg_q  <= 1'b0;
      rtg_q  <= 1'b0;
      rsp1_q <= 1'b0;
      rsp2_q <= 1'b0;
    end
    else
    begin
      wr_q   <= wr_d;
      wtg_q  <= wtg_d;
      rtg_q  <= rtg_d;
      rsp1_q <= resp_q;
      rsp2_q <= rsp1_q;
    end
  end

  assign o_respond = rsp2_q;

  // ****************************************
  // core synchronisers
  // ****************************************
  // first stage is read only by the second
  logic [NF+4:0] s1_q, s2_q;
  logic          wtg3_q, rtg3_q;
  logic          rpin_s, sel_n_s, lp_s, wtg_s, rtg_s, wr_ev, rd_ev;
  logic [NF-1:0] cond_s;

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      // reset and select pins idle high, so no false low follows reset
      s1_q   <= {2'b11, {(NF+3){1'b0}}};
      s2_q   <= {2'b11, {(NF+3){1'b0}}};
      wtg3_q <= 1'b0;
      rtg3_q <= 1'b0;
    end
    else
    begin
      s1_q   <= {i_reset_in_n, i_select_in_n, i_low_power_pin, wtg_q, rtg_q, i_other_cond, i_tx_fault, i_los};
      s2_q   <= s1_q;
      wtg3_q <= wtg_s;
      rtg3_q <= rtg_s;
    end
  end

  // the toggle edges mark the stop of a write or read
  assign {rpin_s, sel_n_s, lp_s, wtg_s, rtg_s, cond_s} = s2_q;
  assign wr_ev = wtg_s ^ wtg3_q;
  assign rd_ev = rtg_s ^ rtg3_q;

  // ****************************************
  // reset pin, init and status
  // ****************************************
  phase_t        phase_q, phase_d;
  logic [5:0]    low_cnt_q, low_cnt_d;
  logic [25:0]   init_cnt_q, init_cnt_d;
  logic          dnr_q, dnr_d, iflag_q, iflag_d;
  logic [NF-1:0] flags_q, flags_d, mask_q, mask_d;
  logic          pdown_q, pdown_d, irq_n_q, irq_n_d, lowpwr_q, lowpwr_d;
  logic          pin_reset;

  // short glitches below the minimum pulse are ignored
  assign pin_reset = (low_cnt_q == 6'(RST_MIN));

  always_comb
  begin
    low_cnt_d  = rpin_s ? 6'h00 : (pin_reset ? low_cnt_q : low_cnt_q + 6'h01); // [R1]
    phase_d    = phase_q;
    init_cnt_d = init_cnt_q;
    dnr_d      = dnr_q;
    iflag_d    = iflag_q && !rd_ev;
    // set wins over the read clear
    flags_d    = (rd_ev ? '0 : flags_q) | cond_s; // [R6] [R7] [R8] [R9]
    mask_d     = wr_ev ? wr_q.mask : mask_q; // [R10] [R11] [R16]
    pdown_d    = wr_ev ? wr_q.pdown : pdown_q; // [R14] [R15] [R16]
    unique case (phase_q)
      ST_HOLD:
      begin
        if (rpin_s)
        begin
          phase_d = ST_INIT;
        end
      end
      ST_INIT:
      begin
        init_cnt_d = init_cnt_q + 26'h1;
        if (init_cnt_q == 26'(INIT_CYCLES - 1))
        begin
          phase_d = ST_READY; // [R2]
          dnr_d   = 1'b0; // [R3]
          iflag_d = 1'b1; // [R3]
        end
      end
      ST_READY:
      begin
      end
    endcase
    if (pin_reset)
    begin
      phase_d    = ST_HOLD; // [R1] [R17]
      init_cnt_d = 26'h0;
      dnr_d      = `MM_DNR_RST;
      iflag_d    = 1'b0;
      flags_d    = '0;
      mask_d     = `MM_MASK_RST;
      pdown_d    = `MM_PDOWN_RST;
    end
    // interrupt follows the unmasked latched flags and the init flag
    irq_n_d  = !((|(flags_q & ~mask_q)) || iflag_q); // [R5] [R10] [R11]
    lowpwr_d = lp_s || pdown_q; // [R4] [R14] [R15]
    resp_d   = (phase_q == ST_READY) && !sel_n_s && rpin_s; // [R12] [R13] [R17]
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      phase_q    <= ST_INIT;
      low_cnt_q  <= 6'h00;
      init_cnt_q <= 26'h0;
      dnr_q      <= `MM_DNR_RST;
      iflag_q    <= 1'b0;
      flags_q    <= '0;
      mask_q     <= `MM_MASK_RST;
      pdown_q    <= `MM_PDOWN_RST;
      irq_n_q    <= 1'b1;
      lowpwr_q   <= 1'b0;
      resp_q     <= 1'b0;
    end
    else
    begin
      phase_q    <= phase_d;
      low_cnt_q  <= low_cnt_d;
      init_cnt_q <= init_cnt_d;
      dnr_q      <= dnr_d;
      iflag_q    <= iflag_d;
      flags_q    <= flags_d;
      mask_q     <= mask_d;
      pdown_q    <= pdown_d;
      irq_n_q    <= irq_n_d;
      lowpwr_q   <= lowpwr_d;
      resp_q     <= resp_d;
    end
  end

  assign o_irq_out_n      = irq_n_q;
  assign o_data_not_ready = dnr_q;
  assign o_flags          = flags_q;
  assign o_mask           = mask_q;
  assign o_pdown          = pdown_q;
  assign o_low_power      = lowpwr_q;

  // ****************************************
  // assertions
  // ****************************************
  sequence s_init_end;
    phase_q == ST_INIT && init_cnt_q == 26'(INIT_CYCLES - 1) && !pin_reset;
  endsequence

  sequence s_ready_shown;
    !dnr_q && iflag_q ##1 !irq_n_q;
  endsequence

  property p_rst_min;
    @(posedge i_mclk) disable iff (!i_rst_n)
    pin_reset |=> phase_q == ST_HOLD && dnr_q && flags_q == '0;
  endproperty
  a_rst_min: assert property (p_rst_min) else $error("pin reset not applied"); // [R1]

  property p_init;
    @(posedge i_mclk) disable iff (!i_rst_n)
    s_init_end |=> phase_q == ST_READY;
  endproperty
  a_init: assert property (p_init) else $error("init did not finish"); // [R2]

  property p_ready;
    @(posedge i_mclk) disable iff (!i_rst_n)
    s_init_end ##1 !pin_reset |-> s_ready_shown;
  endproperty
  a_ready: assert property (p_ready) else $error("ready not shown"); // [R3]

  property p_lp_pin;
    @(posedge i_mclk) disable iff (!i_rst_n)
    lp_s |=> lowpwr_q;
  endproperty
  a_lp_pin: assert property (p_lp_pin) else $error("low power pin ignored"); // [R4]

  property p_irq;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (|(flags_q & ~mask_q)) |=> !o_irq_out_n;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not asserted"); // [R5]

  property p_rd_clear;
    @(posedge i_mclk) disable iff (!i_rst_n)
    rd_ev && cond_s == '0 && !pin_reset |=> flags_q == '0 && !iflag_q ##1 o_irq_out_n;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("read did not clear"); // [R6]

  property p_los;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (|cond_s[`MM_LOS_LSB +: `MM_NLOS]) && !pin_reset |=>
      (flags_q[`MM_LOS_LSB +: `MM_NLOS] & $past(cond_s[`MM_LOS_LSB +: `MM_NLOS]))
        == $past(cond_s[`MM_LOS_LSB +: `MM_NLOS]);
  endproperty
  a_los: assert property (p_los) else $error("los flag not set"); // [R7]

  property p_txf;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (|cond_s[`MM_TXF_LSB +: `MM_NTXF]) && !pin_reset |=> (|flags_q[`MM_TXF_LSB +: `MM_NTXF]);
  endproperty
  a_txf: assert property (p_txf) else $error("tx fault flag not set"); // [R8]

  property p_oth;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (|cond_s[`MM_OTH_LSB +: `MM_NOTH]) && !pin_reset |=> (|flags_q[`MM_OTH_LSB +: `MM_NOTH]);
  endproperty
  a_oth: assert property (p_oth) else $error("other flag not set"); // [R9]

  property p_mask_quiet;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (flags_q & ~mask_q) == '0 && !iflag_q |=> o_irq_out_n;
  endproperty
  a_mask_quiet: assert property (p_mask_quiet) else $error("masked flag drove irq"); // [R10]

  property p_wr_take;
    @(posedge i_mclk) disable iff (!i_rst_n)
    wr_ev && !pin_reset |=> mask_q == $past(wr_q.mask) && pdown_q == $past(wr_q.pdown);
  endproperty
  a_wr_take: assert property (p_wr_take) else $error("write not taken"); // [R11] [R16]

  property p_sel_on;
    @(posedge i_mclk) disable iff (!i_rst_n)
    phase_q == ST_READY && !sel_n_s && rpin_s |=> resp_q;
  endproperty
  a_sel_on: assert property (p_sel_on) else $error("select did not enable"); // [R12]

  property p_sel_off;
    @(posedge i_mclk) disable iff (!i_rst_n)
    sel_n_s || !rpin_s |=> !resp_q;
  endproperty
  a_sel_off: assert property (p_sel_off) else $error("answering while off"); // [R13] [R17]

  property p_pdown;
    @(posedge i_mclk) disable iff (!i_rst_n)
    pdown_q |=> lowpwr_q;
  endproperty
  a_pdown: assert property (p_pdown) else $error("power down ignored"); // [R14]

  property p_pup;
    @(posedge i_mclk) disable iff (!i_rst_n)
    !pdown_q && !lp_s |=> !lowpwr_q;
  endproperty
  a_pup: assert property (p_pup) else $error("low power stuck"); // [R15]

endmodule

// file: mm_host_model.sv
// host side two-wire engine model: raises read and write stop events
// assumes the bench calls its tasks; runs on the free link clock
`timescale 1ns/1ns
module mm_host_model
  import mm_pkg::*;
(
  // link clock
  input  wire logic i_link_clk,
  // stop events toward the block
  output logic      o_rd_stop,
  output logic      o_wr_stop,
  output ctl_word_t o_wr_word
);
  // ****************************************
  // idle levels
  // ****************************************
  initial
  begin
    o_rd_stop = 1'b0;
    o_wr_stop = 1'b0;
    o_wr_word = 13'h1fff;
  end

  // one-cycle write stop carrying the whole word
  task automatic send_write(input ctl_word_t w);
    @(posedge i_link_clk);
    o_wr_word <= w;
    o_wr_stop <= 1'b1;
    @(posedge i_link_clk);
    o_wr_stop <= 1'b0;
    o_wr_word <= ~w; // released bus must not look like held data
  endtask

  // one-cycle read stop of the flag bytes
  task automatic send_read();
    @(posedge i_link_clk);
    o_rd_stop <= 1'b1;
    @(posedge i_link_clk);
    o_rd_stop <= 1'b0;
  endtask
endmodule

// file: module_mgmt_control_timing_test.sv
// bench for the management control block, scenarios as tasks
// assumes mm_pkg and mm_host_model; short init count for run time
`timescale 1ns/1ns
module module_mgmt_control_timing_test
  import mm_pkg::*;
;
  localparam int INIT = 20;
  logic        mclk = 1'b0, link_clk = 1'b0, rst_n, reset_in_n, select_in_n, low_power_pin;
  logic [11:0] cond, flags, mask;
  logic        rd_stop, wr_stop, respond, irq_out_n, dnr, pdown, low_power;
  ctl_word_t   wr_word;
  int          n_mismatch = 0, total_checks = 0, cycles = 0;

  // ****************************************
  // clocks, dut and host model
  // ****************************************
  always #25 mclk = ~mclk;
  // 15 ns link clock from uneven halves, phase unrelated
  always
  begin
    #7 link_clk = 1'b1;
    #8 link_clk = 1'b0;
  end

  mm_ctrl #(.INIT_CYCLES(INIT)) i_mm_ctrl (.i_mclk(mclk), .i_rst_n(rst_n), .i_reset_in_n(reset_in_n),
    .i_select_in_n(select_in_n), .i_low_power_pin(low_power_pin), .i_los(cond[3:0]),
    .i_tx_fault(cond[7:4]), .i_other_cond(cond[11:8]), .i_link_clk(link_clk), .i_rd_stop(rd_stop),
    .i_wr_stop(wr_stop), .i_wr_word(wr_word), .o_respond(respond), .o_irq_out_n(irq_out_n),
    .o_data_not_ready(dnr), .o_flags(flags), .o_mask(mask), .o_pdown(pdown), .o_low_power(low_power));
  mm_host_model i_mm_host_model (.i_link_clk(link_clk), .o_rd_stop(rd_stop), .o_wr_stop(wr_stop),
    .o_wr_word(wr_word));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // read clears flags; a flag whose condition persists keeps the interrupt low
  task automatic clear_read(input logic [11:0] exp_flags);
    i_mm_host_model.send_read();
    cyc(10);
    chk(flags, exp_flags);
    chk(irq_out_n, exp_flags == 12'h000);
  endtask

  // bounded wait for init done, then init interrupt
  task automatic wait_ready();
    int n;
    n = 0;
    while (dnr !== 1'b0 && n < INIT + 200)
    begin
      @(posedge mclk);
      n++;
    end
    chk(n < INIT + 200, 1'b1);
    cyc(10);
    chk(irq_out_n, 1'b0);
    chk(respond, 1'b1);
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_init();
    chk({dnr, irq_out_n, respond, low_power, pdown}, 5'h18);
    chk(flags | mask, 12'h000);
    rst_n <= 1'b1;
    wait_ready();
    clear_read(12'h000);
  endtask

  // each flag in turn: set, interrupt, clear on read
  task automatic t_flags();
    for (int i = 0; i < 12; i++)
    begin
      cond <= 12'h001 << i;
      cyc(10);
      chk(flags, 12'h001 << i);
      chk(irq_out_n, 1'b0);
      cond <= 12'h000;
      clear_read(12'h000);
    end
    cond <= 12'h002;
    cyc(10);
    clear_read(12'h002);
    cond <= 12'h000;
    clear_read(12'h000);
  endtask

  task automatic t_mask();
    i_mm_host_model.send_write('{mask: 12'h801, pdown: 1'b0});
    cyc(10);
    chk(mask, 12'h801);
    cond <= 12'h801;
    cyc(10);
    chk(flags, 12'h801);
    chk(irq_out_n, 1'b1);
    i_mm_host_model.send_write('{mask: 12'h800, pdown: 1'b0});
    cyc(10);
    chk(irq_out_n, 1'b0);
    cond <= 12'h000;
    clear_read(12'h000);
  endtask

  task automatic t_power();
    low_power_pin <= 1'b1;
    cyc(10);
    chk(low_power, 1'b1);
    low_power_pin <= 1'b0;
    i_mm_host_model.send_write('{mask: 12'h000, pdown: 1'b1});
    cyc(10);
    chk({pdown, low_power}, 2'h3);
    i_mm_host_model.send_write('{mask: 12'h0f0, pdown: 1'b0});
    cyc(10);
    chk({pdown, low_power}, 2'h0);
  endtask

  task automatic t_select();
    select_in_n <= 1'b1;
    cyc(10);
    chk(respond, 1'b0);
    select_in_n <= 1'b0;
    cyc(10);
    chk(respond, 1'b1);
  endtask

  // short pulse ignored, long pulse resets and reinitialises
  task automatic t_pin_reset();
    reset_in_n <= 1'b0;
    cyc(10);
    reset_in_n <= 1'b1;
    cyc(10);
    chk({mask, dnr}, 13'h1e0);
    reset_in_n <= 1'b0;
    cyc(50);
    chk({respond, dnr}, 2'h1);
    chk(mask, 12'h000);
    reset_in_n <= 1'b1;
    wait_ready();
    clear_read(12'h000);
  endtask

  // ****************************************
  // main sequence and hang guard
  // ****************************************
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    reset_in_n = 1'b1;
    select_in_n = 1'b0;
    low_power_pin = 1'b0;
    cond = 12'h000;
    cyc(10);
    t_init();
    t_flags();
    t_mask();
    t_power();
    t_select();
    t_pin_reset();
    print_verdict();
  end
endmodule
